// *** shared/lrx_regs.svh ***
`ifndef LRX_REGS_SVH
`define LRX_REGS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define LRX_OFS_BLOCK_CTRL 8'h00
`define LRX_OFS_RX_CTRL    8'h04
`define LRX_OFS_STATUS     8'h08
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LRX_BC_SINGLE_RAIL 0
`define LRX_BC_E3          1
`define LRX_BC_STS1        2
`define LRX_RC_MONITOR     0
`define LRX_RC_CLK_INVERT  1
`define LRX_RC_SDO_DATA    2
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LRX_BC_RESET       32'h0000_0000
`define LRX_RC_RESET       32'h0000_0000
// ------------------------------------------------------------
// timing: synthesizer divider counts (reference clock cycles)
// ------------------------------------------------------------
`define LRX_DIV_E3         4'h2
`define LRX_DIV_DS3        4'h3
`define LRX_DIV_STS1       4'h4
`endif

// *** shared/lrx_pkg.sv ***
package lrx_pkg;
   typedef enum logic [1:0] {LRX_DS3, LRX_E3, LRX_STS1} lrx_rate_t;
   typedef enum logic [1:0] {LRX_AH_IDLE, LRX_AH_WR, LRX_AH_RD} lrx_ahb_st_t;
endpackage

// *** hdl/lrx_clk_synth.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// clock synthesizer: divides reference by a rate-selected count
// ------------------------------------------------------------
module lrx_clk_synth #(
   parameter int CW = 4
) (
   input  wire logic          ref_clk,
   input  wire logic          ref_rst_n,
   input  wire logic          enable,
   input  wire logic [CW-1:0] half_count,
   output logic               clk_out
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          clk;
   } lrx_syn_t;
   lrx_syn_t s_q, s_d;

   // toggle output every half_count reference edges
   always_comb begin
      s_d = s_q;
      if (!enable) begin
         s_d.cnt = '0;
         s_d.clk = 1'b0;
      end else if (s_q.cnt >= half_count - 1'b1) begin
         s_d.cnt = '0;
         s_d.clk = ~s_q.clk;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge ref_rst_n) begin
      if (!ref_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign clk_out = s_q.clk;
endmodule

// *** hdl/lrx_rx_out.sv ***
`timescale 1ns/1ps
// Overview of operation
// - dual-rail: each negative line pulse appears on the negative rail output
// - hardware mode: format pin high selects single-rail, low dual-rail
// - host mode: block control register bit chooses the rail format
// - single-rail: shared output pulses high on each code violation
// - hardware mode: monitor pin high selects monitoring mode
// - host mode: receive control register bit selects monitoring mode
// - host mode: monitor pin becomes the serial data output
// - single-frequency: 12.288 MHz reference, line rate synthesized
// - single-frequency: low-jitter clock out, rate set by line mode
// - single-rail enables the zero-substitution coder, dual-rail disables it
// - hardware mode: E3 pin wins, else sonet pin picks STS-1 or DS3
// - host/hardware pin high selects host mode, low hardware mode
// - rail outputs update on rising recovered clock, falling when inverted
module lrx_rx_out (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        haddr_sel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        recovered_clock,
   input  wire logic        rx_pos_pulse,
   input  wire logic        rx_neg_pulse,
   input  wire logic        rx_code_violation,
   input  wire logic        host_or_hw_select,
   input  wire logic        rail_format_select,
   input  wire logic        monitor_select_or_serial_in,
   input  wire logic        e3_select,
   input  wire logic        sonet_or_ds3_select,
   input  wire logic        recovered_clock_invert,
   input  wire logic        single_freq_enable,
   input  wire logic        reference_clock_in,
   output logic             pos_rail_out,
   output logic             neg_rail_or_violation_out,
   output logic             recovered_clock_out,
   output logic             monitor_select_or_serial_out,
   output logic             monitor_serial_oe_n,
   output logic             monitor_mode,
   output logic             coder_enable,
   output logic             synth_clock_out,
   output logic [1:0]       line_rate
);
   import lrx_pkg::*;
`include "lrx_regs.svh"

   // ---------------------------------------------------------
   // bus-side state
   // ---------------------------------------------------------
   typedef struct packed {
      lrx_ahb_st_t st;
      logic [7:0]  addr;
      logic [31:0] block_ctrl;
      logic [31:0] rx_ctrl;
      logic [31:0] rdata;
      logic [1:0]  host_s;
      logic [1:0]  fmt_s;
      logic [1:0]  mon_s;
      logic [1:0]  e3_s;
      logic [1:0]  sts_s;
      logic [1:0]  inv_s;
      logic [1:0]  sfm_s;
      logic        host;
      logic        single_rail;
      logic        monitor;
      logic        invert;
      logic        sfm;
      lrx_rate_t   rate;
      logic        host_serial_out;
      logic        sdo_oe_n;
   } lrx_bus_t;
   lrx_bus_t b_q, b_d;

   // rate decode shared by both control modes
   function automatic lrx_rate_t rate_of(input logic e3, input logic sts);
      if (e3) begin
         rate_of = LRX_E3;
      end else if (sts) begin
         rate_of = LRX_STS1;
      end else begin
         rate_of = LRX_DS3;
      end
   endfunction

   // synthesizer half-period count for a rate
   function automatic logic [3:0] div_of(input lrx_rate_t r);
      case (r)
         LRX_E3:   div_of = `LRX_DIV_E3;
         LRX_STS1: div_of = `LRX_DIV_STS1;
         default:  div_of = `LRX_DIV_DS3;
      endcase
   endfunction

   // ---------------------------------------------------------
   // pin synchronisers, mode selection, ahb-lite slave
   // ---------------------------------------------------------
   always_comb begin
      b_d = b_q;
      b_d.host_s = {b_q.host_s[0], host_or_hw_select};
      b_d.fmt_s  = {b_q.fmt_s[0], rail_format_select};
      b_d.mon_s  = {b_q.mon_s[0], monitor_select_or_serial_in};
      b_d.e3_s   = {b_q.e3_s[0], e3_select};
      b_d.sts_s  = {b_q.sts_s[0], sonet_or_ds3_select};
      b_d.inv_s  = {b_q.inv_s[0], recovered_clock_invert};
      b_d.sfm_s  = {b_q.sfm_s[0], single_freq_enable};
      b_d.host   = b_q.host_s[1];
      b_d.sfm    = b_q.sfm_s[1];
      if (b_q.host_s[1]) begin
         b_d.single_rail = b_q.block_ctrl[`LRX_BC_SINGLE_RAIL];
         b_d.monitor     = b_q.rx_ctrl[`LRX_RC_MONITOR];
         b_d.invert      = b_q.rx_ctrl[`LRX_RC_CLK_INVERT];
         b_d.rate = rate_of(b_q.block_ctrl[`LRX_BC_E3],
                            b_q.block_ctrl[`LRX_BC_STS1]);
         b_d.host_serial_out      = b_q.rx_ctrl[`LRX_RC_SDO_DATA];
         b_d.sdo_oe_n = 1'b0;
      end else begin
         b_d.single_rail = b_q.fmt_s[1];
         b_d.monitor     = b_q.mon_s[1];
         b_d.invert      = b_q.inv_s[1];
         b_d.rate        = rate_of(b_q.e3_s[1], b_q.sts_s[1]);
         b_d.host_serial_out         = 1'b0;
         b_d.sdo_oe_n    = 1'b1;
      end
      // data phase of the previous address phase
      if (b_q.st == LRX_AH_WR) begin
         case (b_q.addr)
            `LRX_OFS_BLOCK_CTRL: b_d.block_ctrl = hwdata & 32'h0000_0007;
            `LRX_OFS_RX_CTRL:    b_d.rx_ctrl    = hwdata & 32'h0000_0007;
            default: ;
         endcase
      end
      b_d.st = LRX_AH_IDLE;
      if (haddr_sel && hready && htrans[1]) begin
         b_d.addr = haddr[7:0];
         b_d.st   = hwrite ? LRX_AH_WR : LRX_AH_RD;
         case (haddr[7:0])
            `LRX_OFS_BLOCK_CTRL: b_d.rdata = b_q.block_ctrl;
            `LRX_OFS_RX_CTRL:    b_d.rdata = b_q.rx_ctrl;
            `LRX_OFS_STATUS:     b_d.rdata = {26'h0, b_q.rate, b_q.sfm,
                                   b_q.monitor, b_q.single_rail, b_q.host};
            default:             b_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         b_q            <= '0;
         b_q.block_ctrl <= `LRX_BC_RESET;
         b_q.rx_ctrl    <= `LRX_RC_RESET;
         b_q.st         <= LRX_AH_IDLE;
         b_q.rate       <= LRX_DS3;
         b_q.sdo_oe_n   <= 1'b1;
      end else begin
         b_q <= b_d;
      end
   end

   assign hrdata    = b_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign monitor_mode = b_q.monitor;
   assign coder_enable = b_q.single_rail;
   assign line_rate    = b_q.rate;
   assign monitor_select_or_serial_out = b_q.host_serial_out;
   assign monitor_serial_oe_n          = b_q.sdo_oe_n;

   // ---------------------------------------------------------
   // recovered-clock domain: rail formatting
   // ---------------------------------------------------------
   typedef struct packed {
      logic [1:0] fmt_s;
      logic [1:0] inv_s;
      logic       pos;
      logic       neg;
   } lrx_rx_t;
   lrx_rx_t r_q, r_d;
   logic    fall_pos_q;
   logic    fall_neg_q;

   // negative rail or violation strobe by format
   always_comb begin
      r_d = r_q;
      r_d.fmt_s = {r_q.fmt_s[0], b_q.single_rail};
      r_d.inv_s = {r_q.inv_s[0], b_q.invert};
      r_d.pos   = rx_pos_pulse;
      if (r_q.fmt_s[1]) begin
         r_d.neg = rx_code_violation;
      end else begin
         r_d.neg = rx_neg_pulse;
      end
   end

   always_ff @(posedge recovered_clock or negedge hresetn) begin
      if (!hresetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // falling-edge copies for inverted clock
   always_ff @(negedge recovered_clock or negedge hresetn) begin
      if (!hresetn) begin
         fall_pos_q <= 1'b0;
         fall_neg_q <= 1'b0;
      end else begin
         fall_pos_q <= r_q.pos;
         fall_neg_q <= r_q.neg;
      end
   end

   // strobe meant to be sampled on recovered_clock_out
   assign pos_rail_out = r_q.inv_s[1] ? fall_pos_q : r_q.pos;
   assign neg_rail_or_violation_out =
      r_q.inv_s[1] ? fall_neg_q : r_q.neg;
   assign recovered_clock_out = recovered_clock;

   // ---------------------------------------------------------
   // reference-clock domain: synthesizer
   // ---------------------------------------------------------
   logic [1:0] ref_rst_s;
   logic [1:0] ref_sfm_s;
   logic [1:0] ref_rate_s0;
   logic [1:0] ref_rate_s1;
   logic [1:0] ref_rate_s2;
   logic [1:0] ref_rate_q;

   // reset and setting synchronisers
   always_ff @(posedge reference_clock_in or negedge hresetn) begin
      if (!hresetn) begin
         ref_rst_s   <= 2'h0;
         ref_sfm_s   <= 2'h0;
         ref_rate_s0 <= 2'h0;
         ref_rate_s1 <= 2'h0;
         ref_rate_s2 <= 2'h0;
         ref_rate_q  <= 2'h0;
      end else begin
         ref_rst_s   <= {ref_rst_s[0], 1'b1};
         ref_sfm_s   <= {ref_sfm_s[0], b_q.sfm};
         ref_rate_s0 <= b_q.rate;
         ref_rate_s1 <= ref_rate_s0;
         ref_rate_s2 <= ref_rate_s1;
         // two-bit word: take it only once two samples agree
         if (ref_rate_s1 == ref_rate_s2) begin
            ref_rate_q <= ref_rate_s2;
         end
      end
   end

   lrx_clk_synth #(.CW(4)) u_synth (
      .ref_clk    (reference_clock_in),
      .ref_rst_n  (ref_rst_s[1]),
      .enable     (ref_sfm_s[1]),
      .half_count (div_of(lrx_rate_t'(ref_rate_q))),
      .clk_out    (synth_clock_out)
   );

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   a_host_format: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(b_q.host) ##3 b_q.host |-> b_q.single_rail ==
         $past(b_q.block_ctrl[`LRX_BC_SINGLE_RAIL]))
      else $error("host rail format mismatch");
   a_hw_format: assert property (@(posedge hclk) disable iff (!hresetn)
      (!b_q.host_s[1] && !$past(b_q.host_s[1])) |=> b_q.single_rail ==
         $past(b_q.fmt_s[1]))
      else $error("hw rail format mismatch");
   a_hw_monitor: assert property (@(posedge hclk) disable iff (!hresetn)
      !b_q.host_s[1] |=> monitor_mode == $past(b_q.mon_s[1]))
      else $error("hw monitor mismatch");
   a_host_monitor: assert property (@(posedge hclk) disable iff (!hresetn)
      b_q.host_s[1] |=> monitor_mode == $past(b_q.rx_ctrl[0]))
      else $error("host monitor mismatch");
   a_sdo_drive: assert property (@(posedge hclk) disable iff (!hresetn)
      b_q.host_s[1] |=> !monitor_serial_oe_n)
      else $error("serial out not driven in host mode");
   a_coder_link: assert property (@(posedge hclk) disable iff (!hresetn)
      !b_q.host_s[1] |=> coder_enable == $past(b_q.fmt_s[1]))
      else $error("coder enable differs from format");
   a_rate_e3: assert property (@(posedge hclk) disable iff (!hresetn)
      (!b_q.host_s[1] && b_q.e3_s[1]) |=> line_rate == LRX_E3)
      else $error("e3 pin not honoured");
   a_host_mode: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> b_q.host == $past(b_q.host_s[1]))
      else $error("host select not followed");
   a_dual_neg: assert property (@(posedge recovered_clock)
      disable iff (!hresetn)
      !r_q.fmt_s[1] |=> r_q.neg == $past(rx_neg_pulse))
      else $error("negative rail not passed");
   a_single_lcv: assert property (@(posedge recovered_clock)
      disable iff (!hresetn)
      r_q.fmt_s[1] |=> r_q.neg == $past(rx_code_violation))
      else $error("violation strobe not passed");
   c_host: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(b_q.host));
   c_single: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(b_q.single_rail));
   c_sfm: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(b_q.sfm));
   c_violation_inv: cover property (@(posedge recovered_clock)
      disable iff (!hresetn) r_q.inv_s[1] && r_q.fmt_s[1] && r_q.neg);
   c_dual_neg: cover property (@(posedge recovered_clock)
      disable iff (!hresetn) !r_q.fmt_s[1] && r_q.neg);
endmodule

// *** dv/lrx_framer_model.sv ***
`timescale 1ns/1ps
// ------------------------------
// framer receive side
// ------------------------------
module lrx_framer_model (
   input  wire logic       recovered_clock_out,
   input  wire logic       pos_rail_out,
   input  wire logic       neg_rail_or_violation_out,
   input  wire logic       clear,
   output logic [7:0]      pos_count,
   output logic [7:0]      neg_count,
   output logic            change_level
);
   logic pos_seen;
   logic neg_seen;
   // sample both rails on the recovered clock, count rising pulses
   always @(posedge recovered_clock_out or posedge clear) begin
      if (clear) begin
         {pos_seen, neg_seen, pos_count, neg_count} <= '0;
      end else begin
         pos_seen <= pos_rail_out;
         neg_seen <= neg_rail_or_violation_out;
         if (pos_rail_out && !pos_seen) begin
            pos_count <= pos_count + 8'h01;
         end
         if (neg_rail_or_violation_out && !neg_seen) begin
            neg_count <= neg_count + 8'h01;
         end
      end
   end
   // clock level at the moment the shared rail moves
   always @(neg_rail_or_violation_out) begin
      change_level = recovered_clock_out;
   end
endmodule

// *** dv/test_liu_rx_output_and_refclk_select.sv ***
`timescale 1ns/1ps
`include "lrx_regs.svh"
module test_liu_rx_output_and_refclk_select;
   import lrx_pkg::*;
   logic        hclk, hresetn, haddr_sel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, line_rate;
   logic [2:0]  hsize;
   logic        recovered_clock, rx_pos_pulse, rx_neg_pulse;
   logic        rx_code_violation, host_or_hw_select, rail_format_select;
   logic        monitor_select_or_serial_in, e3_select, sonet_or_ds3_select;
   logic        recovered_clock_invert, single_freq_enable;
   logic        reference_clock_in, pos_rail_out, neg_rail_or_violation_out;
   logic        recovered_clock_out, monitor_select_or_serial_out;
   logic        monitor_serial_oe_n, monitor_mode, coder_enable;
   logic        synth_clock_out, clear, change_level;
   logic [7:0]  pos_count, neg_count;
   int          n_fail, checks, n_synth, n0, n1, n2;
   logic [6:0]  hw [3] = '{7'h2c, 7'h14, 7'h30};
   lrx_rate_t   rate_x [3] = '{LRX_E3, LRX_STS1, LRX_DS3};

   lrx_rx_out i_lrx_rx_out (
      .hclk, .hresetn, .haddr_sel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .recovered_clock, .rx_pos_pulse, .rx_neg_pulse, .rx_code_violation,
      .host_or_hw_select, .rail_format_select, .monitor_select_or_serial_in,
      .e3_select, .sonet_or_ds3_select, .recovered_clock_invert,
      .single_freq_enable, .reference_clock_in, .pos_rail_out,
      .neg_rail_or_violation_out, .recovered_clock_out,
      .monitor_select_or_serial_out, .monitor_serial_oe_n, .monitor_mode,
      .coder_enable, .synth_clock_out, .line_rate
   );
   lrx_framer_model i_lrx_framer_model (
      .recovered_clock_out, .pos_rail_out, .neg_rail_or_violation_out,
      .clear, .pos_count, .neg_count, .change_level
   );

   // ------------------------------
   // clocks and helpers
   // ------------------------------
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // link clock, phase unrelated to the bus clock
   initial begin
      recovered_clock = 1'b0;
      #7.3;
      forever #16 recovered_clock = ~recovered_clock;
   end
   // reference: line-rate clock, or 12.288 mhz in single-frequency
   initial begin
      reference_clock_in = 1'b0;
      forever begin
         if (single_freq_enable === 1'b1) begin
            #40.69;
         end else if (e3_select === 1'b1) begin
            #14.55;
         end else if (sonet_or_ds3_select === 1'b1) begin
            #9.645;
         end else begin
            #11.177;
         end
         reference_clock_in = ~reference_clock_in;
      end
   end
   // count synthesizer output edges
   always @(posedge synth_clock_out) n_synth++;

   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic edge_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      hsize  <= 3'b010;
      edge_ready;
      htrans <= 2'b00;
      hwdata <= d;
      edge_ready;
      rd = hrdata;
   endtask
   task automatic rd_check(input string what, input logic [7:0] a,
                           input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic settle;
      repeat (5) @(posedge hclk);
   endtask
   // pin order: host, format, monitor, e3, sonet, invert, sfm
   task automatic pins(input logic [6:0] v);
      @(posedge hclk);
      {host_or_hw_select, rail_format_select, monitor_select_or_serial_in,
       e3_select, sonet_or_ds3_select, recovered_clock_invert,
       single_freq_enable} <= v;
      settle;
   endtask
   // three pos, three neg and two violation pulses, gaps between
   task automatic link_case(input string what, input logic [7:0] en,
                            input logic lvl);
      @(posedge recovered_clock);
      clear <= 1'b1;
      repeat (4) @(posedge recovered_clock);
      clear <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         @(posedge recovered_clock);
         rx_pos_pulse <= (i % 3 == 0);
         rx_neg_pulse <= (i % 3 == 1);
         rx_code_violation <= (i % 3 == 2) && (i < 6);
         @(posedge recovered_clock);
         {rx_pos_pulse, rx_neg_pulse, rx_code_violation} <= 3'b000;
      end
      repeat (4) @(posedge recovered_clock);
      check({what, " neg"}, neg_count, en);
      check({what, " pos"}, pos_count, 8'h03);
      check({what, " edge"}, change_level, lvl);
   endtask
   task automatic synth_count(output int n);
      repeat (100) @(posedge hclk);
      n_synth = 0;
      repeat (2000) @(posedge hclk);
      n = n_synth;
   endtask

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      hresetn = 1'b0;
      haddr_sel = 1'b1;
      {htrans, hwrite, haddr, hwdata, clear} = '0;
      hsize = 3'b010;
      {rx_pos_pulse, rx_neg_pulse, rx_code_violation} = 3'b000;
      {host_or_hw_select, rail_format_select, monitor_select_or_serial_in,
       e3_select, sonet_or_ds3_select, recovered_clock_invert,
       single_freq_enable} = 7'h00;
      {n_fail, checks, n_synth} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      check("oe_n rst", monitor_serial_oe_n, 1'b1);
      rd_check("block rst", `LRX_OFS_BLOCK_CTRL, `LRX_BC_RESET);
      rd_check("rx rst", `LRX_OFS_RX_CTRL, `LRX_RC_RESET);
      rd_check("unmapped", 8'h0c, 32'h0);
      for (int k = 0; k < 3; k++) begin
         pins(hw[k]);
         check("rate hw", line_rate, rate_x[k]);
         check("coder hw", coder_enable, hw[k][5]);
         check("monitor hw", monitor_mode, hw[k][4]);
         check("oe_n hw", monitor_serial_oe_n, 1'b1);
         rd_check("status hw", `LRX_OFS_STATUS,
                  {26'h0, rate_x[k], 1'b0, hw[k][4], hw[k][5], 1'b0});
      end
      pins(7'h00);
      link_case("hw dual", 8'h03, 1'b1);
      check("pos", pos_count, 8'h03);
      pins(7'h22);
      link_case("hw single inv", 8'h02, 1'b0);
      pins(7'h08);
      synth_count(n0);
      check("synth off", n0, 32'h0);
      pins(7'h09);
      synth_count(n1);
      pins(7'h05);
      synth_count(n2);
      check("synth rate", n1 > n2 && n2 > 0, 1'b1);
      rd_check("status sfm", `LRX_OFS_STATUS, 32'h28);
      pins(7'h4a);
      check("rate host", line_rate, LRX_DS3);
      bus(1'b1, `LRX_OFS_BLOCK_CTRL, 32'h5);
      settle;
      check("coder host", coder_enable, 1'b1);
      check("rate sts1", line_rate, LRX_STS1);
      rd_check("block", `LRX_OFS_BLOCK_CTRL, 32'h5);
      bus(1'b1, `LRX_OFS_RX_CTRL, 32'h5);
      settle;
      check("monitor host", monitor_mode, 1'b1);
      check("sdo high", {monitor_select_or_serial_out,
                         monitor_serial_oe_n}, 2'b10);
      bus(1'b1, `LRX_OFS_RX_CTRL, 32'h2);
      bus(1'b1, `LRX_OFS_BLOCK_CTRL, 32'h0);
      settle;
      check("sdo low", {monitor_select_or_serial_out,
                        monitor_serial_oe_n}, 2'b00);
      link_case("host dual inv", 8'h03, 1'b0);
      bus(1'b1, `LRX_OFS_BLOCK_CTRL, 32'h1);
      bus(1'b1, `LRX_OFS_RX_CTRL, 32'h0);
      settle;
      link_case("host single", 8'h02, 1'b1);
      bus(1'b1, `LRX_OFS_STATUS, 32'hff);
      bus(1'b1, 8'h0c, 32'hff);
      rd_check("status ro", `LRX_OFS_STATUS, 32'h3);
      rd_check("unmapped wr", 8'h0c, 32'h0);
      report_and_stop;
   end
endmodule
